// file: hw/cpu_regs_pkg.sv
// Constants and carrier types for the processor register file
package cpu_regs_pkg;
  // Register offsets on the APB side
  localparam logic [7:0] OFS_PC = 8'h00;
  localparam logic [7:0] OFS_SP = 8'h04;
  localparam logic [7:0] OFS_BASE1 = 8'h08;
  localparam logic [7:0] OFS_BASE2 = 8'h0c;
  localparam logic [7:0] OFS_VEC = 8'h10;
  localparam logic [7:0] OFS_DYN = 8'h14;
  localparam logic [7:0] OFS_MODE = 8'h18;
  // Mode register field positions
  localparam int MB_ACC = 0;
  localparam int MB_GEN = 1;
  localparam int MB_IEN = 2;
  localparam int MB_IM = 3;
  // Reset values
  localparam logic [15:0] RST_PC = 16'h0000;
  localparam logic [7:0] RST_VEC = 8'h00;
  localparam logic [6:0] RST_DYN = 7'h00;
  localparam logic [1:0] RST_IM = 2'h0;
  // Stack moves one 16-bit word per push or pop
  localparam logic [15:0] STACK_STEP = 16'h0002;
  // Flag bit positions
  localparam int FL_C = 0;
  localparam int FL_N = 1;
  localparam int FL_Z = 6;
  localparam int FL_S = 7;
  // 8-bit register index: 0..5 general, 6 flags, 7 accumulator
  localparam logic [2:0] IDX_FLG = 3'h6;
  localparam logic [2:0] IDX_ACC = 3'h7;
  // Arithmetic unit operations
  typedef enum logic [3:0] {
    OP_ADD = 4'h0, OP_SUB = 4'h1, OP_AND = 4'h2, OP_OR = 4'h3,
    OP_XOR = 4'h4, OP_CMP = 4'h5, OP_INC = 4'h6, OP_DEC = 4'h7,
    OP_SHL = 4'h8, OP_SHR = 4'h9, OP_SRA = 4'ha, OP_ROL = 4'hb,
    OP_ROR = 4'hc, OP_SETB = 4'hd, OP_RESB = 4'he, OP_TSTB = 4'hf
  } alu_op_t;
  // Fetch sequence phases, Gray along idle-fetch-refresh
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00, PH_FETCH = 2'b01, PH_REFRESH = 2'b11
  } phase_t;
  // Controls from the decoder, one cycle each
  typedef struct packed {
    logic fetch;
    logic jump;
    logic [15:0] jump_addr;
    logic wr_en;
    logic [2:0] wr_idx;
    logic wr_from_alu;
    logic [7:0] ext_data;
    logic [1:0] rd_pair;
    logic alu_go;
    alu_op_t alu_op;
    logic b_from_ext;
    logic [2:0] b_idx;
    logic [2:0] bit_idx;
    logic swap_acc;
    logic swap_gen;
    logic push;
    logic pop;
    logic idx_go;
    logic idx_sel;
    logic [7:0] disp;
    logic vec_go;
    logic [7:0] vec_low;
  } ctl_t;
endpackage : cpu_regs_pkg

// file: hw/cpu_register_file.sv
// Register file, refresh counter and arithmetic unit of the processor core
// Summary of operation
// - 207 bits of static programmer register storage
// - Two sets of six general registers, pairable
// - Program counter increments after driving address
// - Jump target loads counter, beats incrementer
// - Stack pointer tracks top of external stack
// - Index base plus signed displacement byte
// - Vector page gives high byte, peripheral low
// - Seven-bit refresh counter increments per fetch
// - Refresh address and strobe during decode
// - Software may write the refresh counter
// - Two accumulators each with own flags
// - One exchange swaps accumulator/flag pair
// - One exchange swaps whole general set
// - Arithmetic unit add through bit test
// - Operands and results share internal data bus
// - Fetched opcode latched into instruction register
// - Low seven address lines carry refresh address
// - Reset clears counter, page, refresh, enable, mode
`timescale 1ns/1ps
module cpu_register_file (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Decoder controls
  input wire cpu_regs_pkg::ctl_t ctl,
  // Core outputs
  output logic [15:0] addr_out,
  output logic memory_access_strobe,
  output logic dynamic_memory_strobe,
  output logic [7:0] instr_out,
  output logic [15:0] pair_data,
  output logic [15:0] eff_addr,
  output logic [7:0] alu_result,
  output logic [7:0] flags_out
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [15:0] program_counter;
    logic [15:0] stack_pointer;
    logic [1:0][15:0] index_base;                   // First and second index base
    logic [7:0] vector_page;
    logic [6:0] dynamic_memory_counter;
    logic [1:0][5:0][7:0] gen;                      // Two general sets of six
    logic [1:0][7:0] acc;                           // Two accumulators
    logic [1:0][7:0] flg;                           // Their flag registers
    logic acc_bank;                                 // Active accumulator pair
    logic gen_bank;                                 // Active general set
    logic interrupt_enable_latch;
    logic [1:0] im;                                 // Interrupt mode
    cpu_regs_pkg::phase_t ph;
    logic [15:0] addr;
    logic mem_stb;                                  // Memory access strobe
    logic dyn_stb;                                  // Refresh strobe
    logic [7:0] ir;
    logic [15:0] pair;
    logic [15:0] eff;
    logic [7:0] alu;
    logic [31:0] rdata;
    logic rdy;
    logic err;
    logic [7:0] flgo;                               // Copy of the active flags
  } state_t;

  state_t s_r;                                      // Registered state
  state_t s_nxt;                                    // Next state
  logic [8:0] sum;                                  // Result with carry in bit 8
  logic [7:0] opa;                                  // First operand
  logic [7:0] opb;                                  // Second operand
  logic [7:0] mask;                                 // Bit mask for bit ops
  logic [7:0] wdat;                                 // Byte write data
  logic hit;                                        // Address decodes
  logic [31:0] rd;                                  // Read mux

  // Byte read from the active bank
  function automatic logic [7:0] rd8(input state_t s, input logic [2:0] i);
    logic [7:0] v;
    v = 8'h00;
    if (i == cpu_regs_pkg::IDX_ACC) begin
      v = s.acc[s.acc_bank];
    end else if (i == cpu_regs_pkg::IDX_FLG) begin
      v = s.flg[s.acc_bank];
    end else begin
      v = s.gen[s.gen_bank][i];
    end
    return v;
  endfunction : rd8

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic unit
  always_comb begin
    opa = s_r.acc[s_r.acc_bank];
    opb = ctl.b_from_ext ? ctl.ext_data : rd8(s_r, ctl.b_idx);
    mask = 8'h01 << ctl.bit_idx;
    case (ctl.alu_op)
      cpu_regs_pkg::OP_ADD: sum = {1'b0, opa} + {1'b0, opb};
      cpu_regs_pkg::OP_SUB: sum = {1'b0, opa} - {1'b0, opb};
      cpu_regs_pkg::OP_CMP: sum = {1'b0, opa} - {1'b0, opb};
      cpu_regs_pkg::OP_AND: sum = {1'b0, opa & opb};
      cpu_regs_pkg::OP_OR: sum = {1'b0, opa | opb};
      cpu_regs_pkg::OP_XOR: sum = {1'b0, opa ^ opb};
      cpu_regs_pkg::OP_INC: sum = {1'b0, opa} + 9'h001;
      cpu_regs_pkg::OP_DEC: sum = {1'b0, opa} - 9'h001;
      cpu_regs_pkg::OP_SHL: sum = {opa, 1'b0};
      cpu_regs_pkg::OP_SHR: sum = {opa[0], 1'b0, opa[7:1]};
      cpu_regs_pkg::OP_SRA: sum = {opa[0], opa[7], opa[7:1]};
      cpu_regs_pkg::OP_ROL: sum = {opa[7], opa[6:0], opa[7]};
      cpu_regs_pkg::OP_ROR: sum = {opa[0], opa[0], opa[7:1]};
      cpu_regs_pkg::OP_SETB: sum = {1'b0, opa | mask};
      cpu_regs_pkg::OP_RESB: sum = {1'b0, opa & ~mask};
      cpu_regs_pkg::OP_TSTB: sum = {1'b0, opa & mask};
      default: sum = 9'h000;
    endcase
    wdat = ctl.wr_from_alu ? sum[7:0] : ctl.ext_data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read mux and decode
  always_comb begin
    hit = 1'b1;
    rd = 32'h0000_0000;
    case (paddr)
      cpu_regs_pkg::OFS_PC: rd = {16'h0000, s_r.program_counter};
      cpu_regs_pkg::OFS_SP: rd = {16'h0000, s_r.stack_pointer};
      cpu_regs_pkg::OFS_BASE1: rd = {16'h0000, s_r.index_base[0]};
      cpu_regs_pkg::OFS_BASE2: rd = {16'h0000, s_r.index_base[1]};
      cpu_regs_pkg::OFS_VEC: rd = {24'h00_0000, s_r.vector_page};
      cpu_regs_pkg::OFS_DYN: rd = {25'h000_0000, s_r.dynamic_memory_counter};
      cpu_regs_pkg::OFS_MODE: rd = {27'h000_0000, s_r.im, s_r.interrupt_enable_latch,
                                    s_r.gen_bank, s_r.acc_bank};
      default: hit = 1'b0;                          // Unmapped answers with error
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_nxt = s_r;
    // APB: ready in the first access cycle, no wait states
    s_nxt.rdy = psel && !penable;
    s_nxt.err = psel && !penable && !hit;
    if (psel && !penable) begin
      s_nxt.rdata = rd;
    end
    if (psel && penable && pwrite && s_r.rdy && hit) begin
      case (paddr)
        cpu_regs_pkg::OFS_PC: s_nxt.program_counter = pwdata[15:0];
        cpu_regs_pkg::OFS_SP: s_nxt.stack_pointer = pwdata[15:0];
        cpu_regs_pkg::OFS_BASE1: s_nxt.index_base[0] = pwdata[15:0];
        cpu_regs_pkg::OFS_BASE2: s_nxt.index_base[1] = pwdata[15:0];
        cpu_regs_pkg::OFS_VEC: s_nxt.vector_page = pwdata[7:0];
        cpu_regs_pkg::OFS_DYN: s_nxt.dynamic_memory_counter = pwdata[6:0];
        cpu_regs_pkg::OFS_MODE: begin
          s_nxt.acc_bank = pwdata[cpu_regs_pkg::MB_ACC];
          s_nxt.gen_bank = pwdata[cpu_regs_pkg::MB_GEN];
          s_nxt.interrupt_enable_latch = pwdata[cpu_regs_pkg::MB_IEN];
          s_nxt.im = pwdata[cpu_regs_pkg::MB_IM +: 2];
        end
        default: s_nxt.im = s_r.im;
      endcase
    end
    // Pair read sees contents before this cycle's write
    case (ctl.rd_pair)
      2'h3: s_nxt.pair = {s_r.acc[s_r.acc_bank], s_r.flg[s_r.acc_bank]};
      default: s_nxt.pair = {s_r.gen[s_r.gen_bank][{ctl.rd_pair, 1'b0}],
                             s_r.gen[s_r.gen_bank][{ctl.rd_pair, 1'b1}]};
    endcase
    // Arithmetic result to accumulator (not for compare or bit test) and flags
    if (ctl.alu_go) begin
      s_nxt.alu = sum[7:0];
      if (ctl.alu_op != cpu_regs_pkg::OP_CMP && ctl.alu_op != cpu_regs_pkg::OP_TSTB) begin
        s_nxt.acc[s_r.acc_bank] = sum[7:0];
      end
      s_nxt.flg[s_r.acc_bank][cpu_regs_pkg::FL_Z] = (sum[7:0] == 8'h00);
      s_nxt.flg[s_r.acc_bank][cpu_regs_pkg::FL_S] = sum[7];
      s_nxt.flg[s_r.acc_bank][cpu_regs_pkg::FL_C] = sum[8];
      s_nxt.flg[s_r.acc_bank][cpu_regs_pkg::FL_N] = (ctl.alu_op == cpu_regs_pkg::OP_SUB) ||
          (ctl.alu_op == cpu_regs_pkg::OP_CMP) || (ctl.alu_op == cpu_regs_pkg::OP_DEC);
    end
    // Explicit byte write overrides the arithmetic write
    if (ctl.wr_en) begin
      if (ctl.wr_idx == cpu_regs_pkg::IDX_ACC) begin
        s_nxt.acc[s_r.acc_bank] = wdat;
      end else if (ctl.wr_idx == cpu_regs_pkg::IDX_FLG) begin
        s_nxt.flg[s_r.acc_bank] = wdat;
      end else begin
        s_nxt.gen[s_r.gen_bank][ctl.wr_idx] = wdat;
      end
    end
    // Bank exchanges only flip the select, contents stay
    if (ctl.swap_acc) begin
      s_nxt.acc_bank = ~s_r.acc_bank;
    end
    if (ctl.swap_gen) begin
      s_nxt.gen_bank = ~s_r.gen_bank;
    end
    // Stack moves one word per push or pop
    if (ctl.push) begin
      s_nxt.stack_pointer = s_r.stack_pointer - cpu_regs_pkg::STACK_STEP;
    end else if (ctl.pop) begin
      s_nxt.stack_pointer = s_r.stack_pointer + cpu_regs_pkg::STACK_STEP;
    end
    // Indexed address from base and signed displacement
    if (ctl.idx_go) begin
      s_nxt.eff = s_r.index_base[ctl.idx_sel] + {{8{ctl.disp[7]}}, ctl.disp};
    end
    // Fetch sequence owns the address lines
    case (s_r.ph)
      cpu_regs_pkg::PH_IDLE: begin
        s_nxt.mem_stb = 1'b0;
        s_nxt.dyn_stb = 1'b0;
        if (ctl.fetch) begin
          s_nxt.addr = s_r.program_counter;
          s_nxt.mem_stb = 1'b1;
          s_nxt.program_counter = s_r.program_counter + 16'h0001;
          s_nxt.ph = cpu_regs_pkg::PH_FETCH;
        end else if (ctl.vec_go) begin
          s_nxt.addr = {s_r.vector_page, ctl.vec_low};
        end
      end
      cpu_regs_pkg::PH_FETCH: begin
        s_nxt.ir = ctl.ext_data;
        s_nxt.addr = {s_r.vector_page, 1'b0, s_r.dynamic_memory_counter};
        s_nxt.dyn_stb = 1'b1;
        s_nxt.mem_stb = 1'b1;
        s_nxt.dynamic_memory_counter = s_r.dynamic_memory_counter + 7'h01;
        s_nxt.ph = cpu_regs_pkg::PH_REFRESH;
      end
      cpu_regs_pkg::PH_REFRESH: begin
        s_nxt.mem_stb = 1'b0;
        s_nxt.dyn_stb = 1'b0;
        s_nxt.ph = cpu_regs_pkg::PH_IDLE;
      end
      default: s_nxt.ph = cpu_regs_pkg::PH_IDLE;
    endcase
    // Jump target beats the incrementer
    if (ctl.jump) begin
      s_nxt.program_counter = ctl.jump_addr;
    end
    // Active flags mirrored so the output leaves a flop
    s_nxt.flgo = s_nxt.flg[s_nxt.acc_bank];
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.program_counter <= cpu_regs_pkg::RST_PC;
      s_r.vector_page <= cpu_regs_pkg::RST_VEC;
      s_r.dynamic_memory_counter <= cpu_regs_pkg::RST_DYN;
      s_r.interrupt_enable_latch <= 1'b0;
      s_r.im <= cpu_regs_pkg::RST_IM;
      s_r.ph <= cpu_regs_pkg::PH_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  assign prdata = s_r.rdata;
  assign pready = s_r.rdy;
  assign pslverr = s_r.err;
  assign addr_out = s_r.addr;
  assign memory_access_strobe = s_r.mem_stb;
  assign dynamic_memory_strobe = s_r.dyn_stb;
  assign instr_out = s_r.ir;
  assign pair_data = s_r.pair;
  assign eff_addr = s_r.eff;
  assign alu_result = s_r.alu;
  assign flags_out = s_r.flgo;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_pc_inc;
    ctl.fetch && !ctl.jump && s_r.ph == cpu_regs_pkg::PH_IDLE |=>
      addr_out == $past(s_r.program_counter) &&
      s_r.program_counter == $past(s_r.program_counter) + 16'h0001;
  endproperty
  a_pc_inc: assert property (p_pc_inc) else $error("counter not advanced");

  property p_jump;
    ctl.jump |=> s_r.program_counter == $past(ctl.jump_addr);
  endproperty
  a_jump: assert property (p_jump) else $error("jump not loaded");

  property p_refresh;
    s_r.ph == cpu_regs_pkg::PH_FETCH |=> dynamic_memory_strobe && memory_access_strobe &&
      addr_out[6:0] == $past(s_r.dynamic_memory_counter) ##1 !dynamic_memory_strobe;
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh cycle wrong");

  property p_dyn_inc;
    s_r.ph == cpu_regs_pkg::PH_FETCH |=>
      s_r.dynamic_memory_counter == $past(s_r.dynamic_memory_counter) + 7'h01;
  endproperty
  a_dyn_inc: assert property (p_dyn_inc) else $error("refresh count stuck");

  property p_vec;
    ctl.vec_go && !ctl.fetch && s_r.ph == cpu_regs_pkg::PH_IDLE |=>
      addr_out == {$past(s_r.vector_page), $past(ctl.vec_low)};
  endproperty
  a_vec: assert property (p_vec) else $error("vector address wrong");

  property p_idx;
    ctl.idx_go |=> eff_addr ==
      $past(s_r.index_base[ctl.idx_sel]) + {{8{$past(ctl.disp[7])}}, $past(ctl.disp)};
  endproperty
  a_idx: assert property (p_idx) else $error("indexed address wrong");

  property p_swap_keep;
    ctl.swap_acc && !ctl.alu_go && !ctl.wr_en |=>
      s_r.acc_bank != $past(s_r.acc_bank) && s_r.acc == $past(s_r.acc);
  endproperty
  a_swap_keep: assert property (p_swap_keep) else $error("exchange lost data");

  property p_set_swap;
    ctl.swap_gen && !ctl.wr_en |=>
      s_r.gen_bank != $past(s_r.gen_bank) && s_r.gen == $past(s_r.gen);
  endproperty
  a_set_swap: assert property (p_set_swap) else $error("set exchange wrong");

  property p_push;
    ctl.push |=> s_r.stack_pointer == $past(s_r.stack_pointer) - cpu_regs_pkg::STACK_STEP;
  endproperty
  a_push: assert property (p_push) else $error("stack not moved");

  property p_add;
    ctl.alu_go && ctl.alu_op == cpu_regs_pkg::OP_ADD && !ctl.wr_en |=>
      alu_result == $past(opa) + $past(opb) && s_r.acc[$past(s_r.acc_bank)] == alu_result;
  endproperty
  a_add: assert property (p_add) else $error("add result wrong");

  property p_ready;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("bus answer wrong");

  c_fetch: cover property (ctl.fetch ##1 s_r.ph == cpu_regs_pkg::PH_FETCH
                           ##1 dynamic_memory_strobe);
  c_swap: cover property (ctl.swap_acc ##1 ctl.swap_gen);
  c_apbw: cover property (psel && penable && pwrite && pready);
  c_err: cover property (pslverr);

endmodule : cpu_register_file

// file: tb/ctl_partner.sv
// Decoder-side model: passes bench controls and answers opcode fetches
`timescale 1ns/1ps
module ctl_partner (
  // Bench request
  input wire cpu_regs_pkg::ctl_t req,
  // Core address and strobes
  input wire logic [15:0] addr_out,
  input wire logic memory_access_strobe,
  input wire logic dynamic_memory_strobe,
  // Controls to the core
  output cpu_regs_pkg::ctl_t ctl
);
  ////////////////////////////////////////////////////////////////////////////
  // Memory places the opcode byte on the internal bus in the fetch cycle
  always_comb begin
    ctl = req; // Vector low byte comes from the requester
    if (memory_access_strobe && !dynamic_memory_strobe) begin
      ctl.ext_data = addr_out[7:0] ^ 8'ha5;
    end
  end
endmodule : ctl_partner

// file: tb/cpu_register_file_test.sv
// Self-checking bench for the register file over APB and decoder controls
`timescale 1ns/1ps
module cpu_register_file_test;
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, instr_out, alu_result, flags_out;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] addr_out, pair_data, eff_addr;
  logic mem_stb, dyn_stb, e;
  cpu_regs_pkg::ctl_t req, ctl, c;
  int err_total, n_tests, i;
  // Arithmetic table: accumulator 3c, operand 0f
  cpu_regs_pkg::alu_op_t ops [10] = '{cpu_regs_pkg::OP_ADD, cpu_regs_pkg::OP_SUB,
    cpu_regs_pkg::OP_AND, cpu_regs_pkg::OP_OR, cpu_regs_pkg::OP_XOR, cpu_regs_pkg::OP_INC,
    cpu_regs_pkg::OP_DEC, cpu_regs_pkg::OP_SHL, cpu_regs_pkg::OP_SETB, cpu_regs_pkg::OP_RESB};
  logic [7:0] exps [10] = '{8'h4b, 8'h2d, 8'h0c, 8'h3f, 8'h33, 8'h3d, 8'h3b, 8'h78, 8'h3e, 8'h38};
  ////////////////////////////////////////////////////////////////////////////
  cpu_register_file u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ctl(ctl), .addr_out(addr_out), .memory_access_strobe(mem_stb),
    .dynamic_memory_strobe(dyn_stb), .instr_out(instr_out), .pair_data(pair_data),
    .eff_addr(eff_addr), .alu_result(alu_result), .flags_out(flags_out));
  ctl_partner u_part (.req(req), .addr_out(addr_out), .memory_access_strobe(mem_stb),
    .dynamic_memory_strobe(dyn_stb), .ctl(ctl));
  ////////////////////////////////////////////////////////////////////////////
  // Clock generator, 50 ns period
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Watchdog far beyond the expected run
  initial begin
    #250000;
    err_total++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Compare one value and count it
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One APB transfer, waits for pready under a bound
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Read and compare a register
  task rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, q);
  endtask : rd
  // One-cycle control pulse; outputs settled on return
  task pulse(input cpu_regs_pkg::ctl_t x);
    @(posedge sys_clk);
    req <= x;
    @(posedge sys_clk);
    req <= '0;
    #1;
  endtask : pulse
  // Byte write over the internal bus
  task wbyte(input logic [2:0] idx, input logic [7:0] v);
    c = '0;
    c.wr_en = 1'b1;
    c.wr_idx = idx;
    c.ext_data = v;
    pulse(c);
  endtask : wbyte
  // Read a pair and compare
  task rpair(input logic [1:0] p, input logic [15:0] exp);
    c = '0;
    c.rd_pair = p;
    pulse(c);
    chk("pair", {16'h0, exp}, {16'h0, pair_data});
  endtask : rpair
  // Verdict
  task close_out;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    req = '0;
    err_total = 0;
    n_tests = 0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    // Reset values and an unmapped place
    rd("pc", cpu_regs_pkg::OFS_PC, 32'h0);
    rd("vec", cpu_regs_pkg::OFS_VEC, 32'h0);
    rd("dyn", cpu_regs_pkg::OFS_DYN, 32'h0);
    rd("mode", cpu_regs_pkg::OFS_MODE, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    // Register writes, narrow refresh counter
    apb(1'b1, cpu_regs_pkg::OFS_PC, 32'h0123);
    apb(1'b1, cpu_regs_pkg::OFS_VEC, 32'h12);
    apb(1'b1, cpu_regs_pkg::OFS_DYN, 32'hff);
    rd("dyn", cpu_regs_pkg::OFS_DYN, 32'h7f);
    // Opcode fetch then refresh cycle
    c = '0;
    c.fetch = 1'b1;
    pulse(c);
    chk("fetch_addr", 32'h0123, {16'h0, addr_out});
    chk("fetch_mem_stb", 32'h1, {31'h0, mem_stb});
    chk("fetch_dyn_stb", 32'h0, {31'h0, dyn_stb});
    @(posedge sys_clk);
    #1;
    chk("refresh_stb", 32'h1, {31'h0, dyn_stb & mem_stb});
    chk("refresh_hi", 32'h24, {23'h0, addr_out[15:7]});
    chk("ir", 32'h86, {24'h0, instr_out});
    rd("pc", cpu_regs_pkg::OFS_PC, 32'h0124);
    rd("dyn", cpu_regs_pkg::OFS_DYN, 32'h00);
    // Jump alone, then jump with fetch
    c = '0;
    c.jump = 1'b1;
    c.jump_addr = 16'hbeef;
    pulse(c);
    rd("pc", cpu_regs_pkg::OFS_PC, 32'hbeef);
    c.fetch = 1'b1;
    c.jump_addr = 16'h4000;
    pulse(c);
    rd("pc", cpu_regs_pkg::OFS_PC, 32'h4000);
    rd("dyn", cpu_regs_pkg::OFS_DYN, 32'h01);
    // Vector address from page and peripheral byte
    c = '0;
    c.vec_go = 1'b1;
    c.vec_low = 8'h34;
    pulse(c);
    chk("vec_addr", 32'h1234, {16'h0, addr_out});
    // Stack push then pop
    apb(1'b1, cpu_regs_pkg::OFS_SP, 32'h2000);
    c = '0;
    c.push = 1'b1;
    pulse(c);
    rd("sp_push", cpu_regs_pkg::OFS_SP, 32'h1ffe);
    c = '0;
    c.pop = 1'b1;
    pulse(c);
    rd("sp_pop", cpu_regs_pkg::OFS_SP, 32'h2000);
    // Index bases with signed displacements
    apb(1'b1, cpu_regs_pkg::OFS_BASE1, 32'h1000);
    apb(1'b1, cpu_regs_pkg::OFS_BASE2, 32'h8000);
    c = '0;
    c.idx_go = 1'b1;
    c.disp = 8'hfe;
    pulse(c);
    chk("base1_eff", 32'h0ffe, {16'h0, eff_addr});
    c.idx_sel = 1'b1;
    c.disp = 8'h10;
    pulse(c);
    chk("base2_eff", 32'h8010, {16'h0, eff_addr});
    // General registers, byte order within pairs
    for (i = 0; i < 6; i++) wbyte(i[2:0], 8'h10 + i[7:0]);
    for (i = 0; i < 3; i++) rpair(i[1:0], {8'h10 + 8'(2 * i), 8'h11 + 8'(2 * i)});
    // Pair read sees old value in the write cycle
    c = '0;
    c.wr_en = 1'b1;
    c.wr_idx = 3'h1;
    c.ext_data = 8'h99;
    pulse(c);
    chk("pair_old", 32'h1011, {16'h0, pair_data});
    rpair(2'h0, 16'h1099);
    // Alternate general set
    c = '0;
    c.swap_gen = 1'b1;
    pulse(c);
    rd("mode_gen", cpu_regs_pkg::OFS_MODE, 32'h2);
    wbyte(3'h0, 8'h77);
    rpair(2'h0, 16'h7700);
    c = '0;
    c.swap_gen = 1'b1;
    pulse(c);
    rpair(2'h0, 16'h1099);
    rpair(2'h2, 16'h1415);
    // Arithmetic unit table
    for (i = 0; i < 10; i++) begin
      wbyte(cpu_regs_pkg::IDX_ACC, 8'h3c);
      c = '0;
      c.alu_go = 1'b1;
      c.alu_op = ops[i];
      c.b_from_ext = 1'b1;
      c.ext_data = 8'h0f;
      c.bit_idx = (ops[i] == cpu_regs_pkg::OP_SETB) ? 3'h1 : 3'h2;
      pulse(c);
      chk("alu", {24'h0, exps[i]}, {24'h0, alu_result});
    end
    rpair(2'h3, 16'h3800);
    // Compare sets zero and subtract flags, keeps accumulator
    wbyte(cpu_regs_pkg::IDX_ACC, 8'h3c);
    c = '0;
    c.alu_go = 1'b1;
    c.b_from_ext = 1'b1;
    c.alu_op = cpu_regs_pkg::OP_CMP;
    c.ext_data = 8'h3c;
    pulse(c);
    chk("zero", 32'h1, {31'h0, flags_out[cpu_regs_pkg::FL_Z]});
    rpair(2'h3, 16'h3c42);
    // Alternate accumulator and flags
    c = '0;
    c.swap_acc = 1'b1;
    pulse(c);
    rpair(2'h3, 16'h0000);
    c = '0;
    c.swap_acc = 1'b1;
    pulse(c);
    chk("flags_back", 32'h1, {31'h0, flags_out[cpu_regs_pkg::FL_Z]});
    rd("mode_acc", cpu_regs_pkg::OFS_MODE, 32'h0);
    close_out();
  end
endmodule : cpu_register_file_test
